// >>> logic/encoder_ctrl_params.svh
`ifndef ENCODER_CTRL_PARAMS_SVH
`define ENCODER_CTRL_PARAMS_SVH
// Least run of zero control bits before a frame start bit.
`define ZERO_RUN_MIN 4'he
// Low bits of the control CRC generator 0x13 (x^4 + x + 1).
`define CRC4_POLY 4'h3
// Control type select value for a register access.
`define CTS_REG_ACCESS 1'h1
// Slave identifier of the single attached slave.
`define SLAVE_ID 3'h0
// Bits covered by the outgoing CRC: select, identifier, address.
`define HDR_BITS 11
// Returned data bits covered by the returned CRC.
`define RX_DATA_BITS 8
// Reset value of the returned control word.
`define RESULT_RST 32'h0
// Depth of the host frame word queue.
`define FIFO_DEPTH 16
// Ones in an oversampled byte that make a one.
`define MAJORITY_ONES 4'h4
`endif

// >>> logic/encoder_ctrl_pkg.sv
package encoder_ctrl_pkg;

    // One-hot states of the control channel sequencer.
    typedef enum logic [2:0] {
        CH_IDLE = 3'h1,
        CH_START = 3'h2,
        CH_SEND = 3'h4
    } ch_state_t;

    // Layout of one 32-bit control frame word, first bit sent on top.
    typedef struct packed {
        logic cts;
        logic [2:0] slave_identifier_bits;
        logic [6:0] addr;
        logic [3:0] crc_n;
        logic [2:0] read_write_start_flags;
        logic [13:0] tail;
    } ctl_frame_t;

    // Whole state of the system-side sequencer.
    typedef struct packed {
        ch_state_t st;
        logic [3:0] zeros;
        logic [4:0] idx;
        ctl_frame_t frame;
        logic master_control_bit;
        logic [31:0] shift;
        logic [31:0] result;
        logic result_valid;
        logic cmd_crc_error;
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic bit_s1;
        logic bit_s2;
    } ch_reg_t;

    // Whole state of the link-side bit port.
    typedef struct packed {
        logic [7:0] smp_s1;
        logic [7:0] smp_s2;
        logic mb_s1;
        logic mb_s2;
        logic line;
        logic slave_control_bit;
        logic pend;
        logic tog;
    } link_reg_t;

endpackage : encoder_ctrl_pkg

// >>> logic/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clocking.
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // Fill side.
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // Drain side.
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Storage, pointers and registered handshake flags in one record.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic in_ready;
        logic out_valid;
    } fifo_reg_t;

    fifo_reg_t r;
    fifo_reg_t next_r;

    // Next state: push and pop may happen in the same cycle.
    always_comb begin
        logic push;
        logic pop;
        push = in_valid && r.in_ready;
        pop = out_ready && r.out_valid;
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data;
            next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'h1;
        end
        if (pop) begin
            next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'h1;
        end
        next_r.cnt = r.cnt + CW'(push) - CW'(pop);
        // Flags are registered so that full and empty are exact next cycle.
        next_r.in_ready = next_r.cnt != CW'(DEPTH);
        next_r.out_valid = next_r.cnt != '0;
    end

    // Register the record; the enable freezes everything.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign in_ready = r.in_ready;
    assign out_valid = r.out_valid;
    assign out_data = r.mem[r.rp];
endmodule : word_fifo

// >>> logic/link_bit_port.sv
`timescale 1ns/1ps
`include "encoder_ctrl_params.svh"
module link_bit_port (
    // Link clocking.
    input wire logic link_clk,
    input wire logic link_rst,
    // Link-side timing from the position frame engine.
    input wire logic timeout_active,
    input wire logic frame_data_done,
    input wire logic fast_mode,
    input wire logic [2:0] sample_point,
    // Oversampled data pin byte.
    input wire logic [7:0] slave_samples,
    // Master control bit level from the system domain.
    input wire logic master_control_bit,
    // Outputs toward the line and the system domain.
    output logic master_clock_line,
    output logic slave_control_bit,
    output logic bit_toggle
);
    encoder_ctrl_pkg::link_reg_t r;
    encoder_ctrl_pkg::link_reg_t next_r;
    logic [3:0] ones_lut [256];

    // Precomputed table of ones per byte value, one entry per index.
    for (genvar g = 0; g < 256; g++) begin : g_lut
        assign ones_lut[g] = 4'($countones(8'(g))); // see R17
    end

    // Next state of the link side.
    always_comb begin
        next_r = r;
        next_r.smp_s1 = slave_samples;
        next_r.smp_s2 = r.smp_s1;
        next_r.mb_s1 = master_control_bit;
        next_r.mb_s2 = r.mb_s1;
        // The bit is driven inverted only inside the timeout gap.
        next_r.line = timeout_active ? ~r.mb_s2 : 1'h1; // see R01 see R05
        next_r.pend = 1'h0;
        if (frame_data_done) begin // see R16
            // At the fast rate the raw sample point is used, no filtering.
            if (fast_mode) begin
                next_r.slave_control_bit = r.smp_s2[sample_point]; // see R15
            end else begin
                next_r.slave_control_bit = ones_lut[r.smp_s2] >= `MAJORITY_ONES; // see R17
            end
            next_r.pend = 1'h1;
        end
        // Toggle one cycle after the bit so the bit is settled first.
        if (r.pend) begin
            next_r.tog = ~r.tog;
        end
    end

    // Register the link record.
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            r <= '0;
            r.line <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    assign master_clock_line = r.line;
    assign slave_control_bit = r.slave_control_bit;
    assign bit_toggle = r.tog;
endmodule : link_bit_port

// >>> logic/encoder_control_channel_master.sv
// Overview of operation
// R01 - Control bits only in post-frame timeout, one each.
// R02 - At least fourteen zero bits before frame.
// R03 - First one after zeros is start bit.
// R04 - Select bit one follows start for registers.
// R05 - Control bit sent inverted on clock line.
// R06 - Three identifier bits are all zero.
// R07 - Seven-bit register address, top bit first.
// R08 - CRC 0x13 over select through address.
// R09 - Inverted CRC follows the address bits.
// R10 - Then read, write, start flags; read 101.
// R11 - Host word in, outcome out to result.
// R12 - Host encodes status read/write words.
// R13 - Check returned data with inverted CRC 0x13.
// R14 - CRC mismatch sets host-visible error flag.
// R15 - Fast rate uses unfiltered sample point.
// R16 - Post processing only after all bits.
// R17 - Ones counted by 256-entry table.
// R18 - Collect slave bits into result register.
// R19 - No pending frame: send zero bits.
`timescale 1ns/1ps
`include "encoder_ctrl_params.svh"
module encoder_control_channel_master #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    // System clocking.
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // Link clocking.
    input wire logic link_clk,
    input wire logic link_rst,
    // Host frame word stream.
    input wire logic [31:0] host_word,
    input wire logic host_valid,
    output logic host_ready,
    // Host result and status.
    output logic [31:0] control_result_register,
    output logic result_valid,
    output logic cmd_crc_error,
    input wire logic crc_error_clear,
    output logic busy,
    // Link timing from the position frame engine.
    input wire logic timeout_active,
    input wire logic frame_data_done,
    input wire logic fast_mode,
    input wire logic [2:0] sample_point,
    // Link pins.
    input wire logic [7:0] slave_samples,
    output logic master_clock_line
);

    // ****************************************************************
    // Local signals
    // ****************************************************************

    // Registered sequencer record and its next value.
    encoder_ctrl_pkg::ch_reg_t r;
    encoder_ctrl_pkg::ch_reg_t next_r;

    // Drain side of the host word queue.
    logic [31:0] q_data;
    logic q_valid;
    logic q_pop;

    // Link-side outputs that cross into this domain.
    logic link_bit;
    logic link_tog;

    // Holds the busy output so it comes from a flop.
    logic busy_q;

    // ****************************************************************
    // CRC helper
    // ****************************************************************

    // Serial division by x^4 + x + 1 over the low n bits, top bit first.
    // Starting from zero this equals the long division with four
    // appended zeros.
    function automatic logic [3:0] crc4(input logic [10:0] d, input int n);
        logic [3:0] c;
        logic fb;
        c = 4'h0;
        fb = 1'h0;
        for (int i = 10; i >= 0; i--) begin
            if (i < n) begin
                fb = d[i] ^ c[3];
                c = {c[2:0], 1'h0} ^ (fb ? `CRC4_POLY : 4'h0);
            end
        end
        return c;
    endfunction : crc4

    // ****************************************************************
    // Host word queue
    // ****************************************************************

    // The queue lets the host post several frames; the sequencer only
    // drains it when a frame may start, so the host is stalled when full.
    word_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH)
    ) u_queue (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .in_data(host_word),
        .in_valid(host_valid),
        .in_ready(host_ready),
        .out_data(q_data),
        .out_valid(q_valid),
        .out_ready(q_pop)
    );

    // ****************************************************************
    // Link side
    // ****************************************************************

    // Everything that times itself on the link clock lives here.
    link_bit_port u_link (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .timeout_active(timeout_active),
        .frame_data_done(frame_data_done),
        .fast_mode(fast_mode),
        .sample_point(sample_point),
        .slave_samples(slave_samples),
        .master_control_bit(r.master_control_bit),
        .master_clock_line(master_clock_line),
        .slave_control_bit(link_bit),
        .bit_toggle(link_tog)
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // One step per finished position frame. The bit in
    // master_control_bit is the one the link is sending now; at each
    // frame event it is replaced by the bit for the next gap.
    always_comb begin
        logic frame_evt;
        logic [3:0] zc;
        logic [3:0] rx_crc;
        logic [31:0] sh;
        encoder_ctrl_pkg::ctl_frame_t f;
        next_r = r;
        frame_evt = r.tog_s2 ^ r.tog_s3;
        q_pop = 1'h0;
        zc = r.zeros;
        rx_crc = 4'h0;
        sh = r.shift;
        f = encoder_ctrl_pkg::ctl_frame_t'(q_data);

        // Toggle and bit each pass two flops before use.
        next_r.tog_s1 = link_tog;
        next_r.tog_s2 = r.tog_s1;
        next_r.tog_s3 = r.tog_s2;
        next_r.bit_s1 = link_bit;
        next_r.bit_s2 = r.bit_s1;

        // Result strobe lasts one cycle.
        next_r.result_valid = 1'h0;

        // Clearing the error flag loses to a new error below.
        if (crc_error_clear) begin
            next_r.cmd_crc_error = 1'h0;
        end

        if (frame_evt) begin // see R01
            unique case (r.st)
                encoder_ctrl_pkg::CH_IDLE: begin
                    // Count zeros already sent, saturating at the run.
                    if (!r.master_control_bit && r.zeros != `ZERO_RUN_MIN) begin
                        zc = r.zeros + 4'h1;
                    end
                    next_r.zeros = zc;
                    next_r.master_control_bit = 1'h0; // see R19
                    // Start only on a run counted before this event: the
                    // first event after reset has no gap behind it.
                    if (r.zeros == `ZERO_RUN_MIN && q_valid) begin // see R02
                        // Fix the header fields and insert the CRC so a
                        // bad host word cannot put a wrong check on line.
                        f.cts = `CTS_REG_ACCESS; // see R04
                        f.slave_identifier_bits = `SLAVE_ID; // see R06
                        f.crc_n = ~crc4({f.cts, f.slave_identifier_bits, f.addr},
                            `HDR_BITS); // see R08 see R09
                        next_r.frame = f; // see R07 see R10 see R11
                        q_pop = 1'h1;
                        next_r.master_control_bit = 1'h1; // see R03
                        next_r.st = encoder_ctrl_pkg::CH_START;
                    end
                end
                encoder_ctrl_pkg::CH_START: begin
                    // Start bit went out; the word follows top bit first.
                    next_r.master_control_bit = r.frame[31]; // see R07
                    next_r.idx = 5'h1f;
                    next_r.shift = `RESULT_RST;
                    next_r.st = encoder_ctrl_pkg::CH_SEND;
                end
                encoder_ctrl_pkg::CH_SEND: begin
                    // Keep the slave answer to the bit just sent.
                    sh = {r.shift[30:0], r.bit_s2}; // see R18
                    next_r.shift = sh;
                    if (r.idx == 5'h0) begin
                        // Last bit answered: check and publish.
                        rx_crc = crc4({3'h0, sh[11:4]}, `RX_DATA_BITS);
                        if (sh[3:0] != ~rx_crc) begin // see R13
                            next_r.cmd_crc_error = 1'h1; // see R14
                        end
                        next_r.result = sh; // see R11 see R18
                        next_r.result_valid = 1'h1;
                        next_r.master_control_bit = 1'h0; // see R19
                        next_r.zeros = 4'h0;
                        next_r.st = encoder_ctrl_pkg::CH_IDLE;
                    end else begin
                        next_r.idx = r.idx - 5'h1;
                        next_r.master_control_bit = r.frame[r.idx - 5'h1];
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************

    // The clock enable freezes the sequencer and its synchronisers.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r <= '0;
            r.st <= encoder_ctrl_pkg::CH_IDLE;
            busy_q <= 1'h0;
        end else if (ce) begin
            r <= next_r;
            busy_q <= next_r.st != encoder_ctrl_pkg::CH_IDLE;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // All of these are plain flop outputs.
    assign control_result_register = r.result;
    assign result_valid = r.result_valid;
    assign cmd_crc_error = r.cmd_crc_error;
    assign busy = busy_q;

endmodule : encoder_control_channel_master

// >>> tb/encoder_ctrl_props.sv
`timescale 1ns/1ps
`include "encoder_ctrl_params.svh"
// ****
// Port checker for the control channel.
// ****
module encoder_ctrl_props (
    // Clocks and resets.
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic link_clk,
    input wire logic link_rst,
    // Host side.
    input wire logic host_ready,
    input wire logic [31:0] control_result_register,
    input wire logic result_valid,
    input wire logic cmd_crc_error,
    input wire logic crc_error_clear,
    // Link side.
    input wire logic timeout_active,
    input wire logic master_clock_line
);
    logic [3:0] gaps; // Gaps since link reset, saturating.
    // Count gaps so the lead-in zero run can be watched on the line.
    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            gaps <= 4'h0;
        end else if ($fell(timeout_active) && gaps != 4'hf) begin
            gaps <= gaps + 4'h1;
        end
    end
    a_line_idle_high: assert property (@(posedge link_clk) disable iff (link_rst)
        !timeout_active |=> master_clock_line) else $error("clock line low outside gap");
    a_lead_zeros: assert property (@(posedge link_clk) disable iff (link_rst)
        timeout_active && gaps < `ZERO_RUN_MIN |=> master_clock_line)
        else $error("one sent before zero run");
    a_reset_quiet: assert property (@(posedge clock) sys_rst |=> !host_ready
        && !result_valid && !cmd_crc_error && control_result_register == 32'h0)
        else $error("outputs not quiet in reset");
    a_ready_release: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(sys_rst) && ce |-> ##[1:3] host_ready) else $error("not ready after reset");
    a_result_pulse: assert property (@(posedge clock) disable iff (sys_rst)
        result_valid |=> !result_valid) else $error("result pulse too long");
    a_result_hold: assert property (@(posedge clock) disable iff (sys_rst)
        $changed(control_result_register) |-> result_valid) else $error("result moved");
    a_error_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_crc_error && !crc_error_clear |=> cmd_crc_error) else $error("error flag lost");
    a_error_clear: assert property (@(posedge clock) disable iff (sys_rst)
        crc_error_clear && ce |=> !cmd_crc_error || result_valid) else $error("clear ignored");
    a_error_cause: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(cmd_crc_error) |-> result_valid || $past(result_valid))
        else $error("error without result");
    c_bad_crc: cover property (@(posedge clock) result_valid && cmd_crc_error);
    c_full: cover property (@(posedge clock) $fell(host_ready) && !sys_rst);
    c_one_sent: cover property (@(posedge link_clk) timeout_active && !master_clock_line);
endmodule : encoder_ctrl_props
bind encoder_control_channel_master encoder_ctrl_props i_props (
    .clock(clock), .sys_rst(sys_rst), .ce(ce), .link_clk(link_clk), .link_rst(link_rst),
    .host_ready(host_ready), .control_result_register(control_result_register),
    .result_valid(result_valid), .cmd_crc_error(cmd_crc_error),
    .crc_error_clear(crc_error_clear), .timeout_active(timeout_active),
    .master_clock_line(master_clock_line)
);

// >>> tb/encoder_slave_model.sv
`timescale 1ns/1ps
// ****
// Single position encoder on the far side of the link.
// ****
module encoder_slave_model (
    // Link clocking.
    input wire logic link_clk,
    input wire logic link_rst,
    // Bench controls.
    input wire logic slow,
    input wire logic fast_mode,
    input wire logic [2:0] sample_point,
    input wire logic [31:0] reply,
    // Line signals.
    input wire logic master_clock_line,
    output logic timeout_active,
    output logic frame_data_done,
    output logic [7:0] slave_samples,
    // Decoded control frame word.
    output logic [31:0] got_word
);
    int zeros; // Zero control bits in a row.
    int nb; // Next word bit, or -1 while hunting a start bit.
    logic mbit; // Control bit read in this gap.
    logic sbit; // Control bit answered in the next frame.
    logic [7:0] pat; // Sample byte of this frame.
    // Frame loop: body, done pulse, then the timeout gap.
    initial begin
        timeout_active = 1'b0;
        frame_data_done = 1'b0;
        got_word = 32'h0;
        zeros = 0;
        nb = -1;
        sbit = 1'b0;
        forever begin
            // Fast frames hold the bit only at the sample point, so a vote reads it wrong.
            pat = {8{~sbit}} ^ (8'h01 << sample_point);
            if (!fast_mode) begin
                pat = ~pat ^ (8'h01 << (sample_point ^ 3'h4)) ^ (8'h01 << (sample_point ^ 3'h2));
            end
            slave_samples <= pat;
            repeat (slow ? 24 : 12) @(posedge link_clk);
            frame_data_done <= 1'b1;
            @(posedge link_clk);
            frame_data_done <= 1'b0;
            timeout_active <= 1'b1;
            slave_samples <= ~pat; // A released line shows no stale value.
            repeat (8) @(posedge link_clk);
            mbit = ~master_clock_line;
            timeout_active <= 1'b0;
            sbit = 1'b0;
            if (link_rst) begin
                zeros = 0;
                nb = -1;
            end else if (nb >= 0) begin
                got_word[nb] = mbit;
                sbit = reply[nb];
                nb = nb - 1;
            end else if (mbit) begin
                nb = (zeros >= 14) ? 31 : -1;
                zeros = 0;
            end else begin
                zeros = zeros + 1;
            end
        end
    end
endmodule : encoder_slave_model

// >>> tb/encoder_control_channel_master_test.sv
`timescale 1ns/1ps
`include "encoder_ctrl_params.svh"
module encoder_control_channel_master_test;
    localparam int DEPTH = 4; // A short queue keeps the fill test brief.
    logic clock, sys_rst, ce, link_clk, link_rst, host_valid, host_ready;
    logic [31:0] host_word, control_result_register, reply, got_word;
    logic result_valid, cmd_crc_error, crc_error_clear, busy, err_exp;
    logic timeout_active, frame_data_done, fast_mode, slow, master_clock_line;
    logic [2:0] sample_point;
    logic [7:0] slave_samples;
    int fails, compares;
    // ****
    // Clocks, design and far side.
    // ****
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    encoder_control_channel_master #(.DEPTH(DEPTH)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .ce(ce), .link_clk(link_clk), .link_rst(link_rst),
        .host_word(host_word), .host_valid(host_valid), .host_ready(host_ready),
        .control_result_register(control_result_register), .result_valid(result_valid),
        .cmd_crc_error(cmd_crc_error), .crc_error_clear(crc_error_clear), .busy(busy),
        .timeout_active(timeout_active), .frame_data_done(frame_data_done),
        .fast_mode(fast_mode), .sample_point(sample_point), .slave_samples(slave_samples),
        .master_clock_line(master_clock_line));
    encoder_slave_model i_slave (
        .link_clk(link_clk), .link_rst(link_rst), .slow(slow), .fast_mode(fast_mode),
        .sample_point(sample_point), .reply(reply), .master_clock_line(master_clock_line),
        .timeout_active(timeout_active), .frame_data_done(frame_data_done),
        .slave_samples(slave_samples), .got_word(got_word));
    task automatic finish_test();
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp, input string what);
        check_word({31'h0, got}, {31'h0, exp}, what);
    endtask : check_bit
    // Bit-serial remainder, top bit first, as the line carries it.
    function automatic logic [3:0] crc4(input logic [31:0] v, input int n);
        logic [3:0] c;
        c = 4'h0;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? `CRC4_POLY : 4'h0);
        end
        return c;
    endfunction : crc4
    // The word as it must appear on the line with the fixed header.
    function automatic logic [31:0] framed(input logic [31:0] w);
        logic [31:0] f;
        f = {1'b1, 3'h0, w[27:0]};
        f[20:17] = ~crc4(f >> 21, 11);
        return f;
    endfunction : framed
    function automatic logic [31:0] good(input logic [7:0] d);
        return {16'h5a3c, 4'h0, d, ~crc4({24'h0, d}, 8)};
    endfunction : good
    task automatic give_up(input string what);
        fails++;
        $display("ERROR %0t %s timed out", $time, what);
        finish_test();
    endtask : give_up
    // Offer one word and hold it until the queue takes it.
    task automatic push(input logic [31:0] w);
        int n;
        n = 0;
        host_word = w;
        host_valid = 1'b1;
        while (host_ready !== 1'b1 && n < 1000) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        host_valid = 1'b0;
        if (n >= 1000) begin
            give_up("push");
        end
    endtask : push
    task automatic wait_result();
        int n;
        int hi;
        n = 0;
        hi = 0;
        do begin
            @(negedge clock);
            n++;
            hi += (busy === 1'b1);
        end while (result_valid !== 1'b1 && n < 60000);
        if (n >= 60000) begin
            give_up("result");
        end
        check_bit(hi != 0 && busy === 1'b0, 1'b1, "busy");
    endtask : wait_result
    // One whole transfer, judged on the line, the result and the flag.
    task automatic run_frame(input logic [31:0] w, input logic [31:0] r);
        reply = r;
        push(w);
        wait_result();
        @(negedge clock);
        err_exp = err_exp | (r[3:0] != ~crc4(r >> 4, 8));
        check_word(control_result_register, r, "result");
        check_word(got_word, framed(w), "frame");
        check_bit(cmd_crc_error, err_exp, "crc flag");
    endtask : run_frame
    // ****
    // Scenarios.
    // ****
    task automatic sc_status_read();
        run_frame(32'h8c174000, good(8'ha5));
    endtask : sc_status_read
    task automatic sc_bad_header();
        run_frame(32'h7a5a7fff, good(8'h3c) ^ 32'h1);
        crc_error_clear = 1'b1;
        @(negedge clock);
        crc_error_clear = 1'b0;
        err_exp = 1'b0;
        @(negedge clock);
        check_bit(cmd_crc_error, 1'b0, "flag clear");
    endtask : sc_bad_header
    task automatic sc_write_fast();
        fast_mode = 1'b1;
        sample_point = 3'h5;
        run_frame(32'h8c13c194, good(8'h96));
        fast_mode = 1'b0;
    endtask : sc_write_fast
    // Fill the queue while the encoder answers slowly, then drain it.
    task automatic sc_fill();
        int taken;
        taken = 0;
        slow = 1'b1;
        reply = good(8'h0f);
        host_word = 32'h8c174000;
        host_valid = 1'b1;
        while (host_ready === 1'b1 && taken < 20) begin
            @(negedge clock);
            taken++;
        end
        host_valid = 1'b0;
        check_bit(taken == DEPTH || taken == DEPTH + 1, 1'b1, "fill count");
        for (int i = 0; i < taken; i++) begin
            wait_result();
            check_word(control_result_register, reply, "queued result");
        end
        slow = 1'b0;
    endtask : sc_fill
    initial begin
        fails = 0;
        compares = 0;
        ce = 1'b1;
        sys_rst = 1'b1;
        link_rst = 1'b1;
        host_word = 32'h0;
        host_valid = 1'b0;
        crc_error_clear = 1'b0;
        fast_mode = 1'b0;
        slow = 1'b0;
        sample_point = 3'h2;
        reply = 32'h0;
        err_exp = 1'b0;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        link_rst = 1'b0;
        sc_status_read();
        sc_bad_header();
        sc_write_fast();
        sc_fill();
        finish_test();
    end
endmodule : encoder_control_channel_master_test
